// ---- logic/fla_link_regs.vh ----
`ifndef FLA_LINK_REGS_VH
`define FLA_LINK_REGS_VH

`define FLA_CLK_PERIOD_NS 5
`define FLA_ANS_TIMEOUT_NS 2000
`define FLA_ANS_TIMEOUT_CYC (`FLA_ANS_TIMEOUT_NS / `FLA_CLK_PERIOD_NS)

`define FLA_OFS_CTRL 12'h000
`define FLA_OFS_SEND_AREA 12'h004
`define FLA_OFS_RECV_AREA 12'h008
`define FLA_OFS_FINAL_ADDR 12'h00C
`define FLA_OFS_STATUS 12'h010
`define FLA_OFS_CYCLE_COUNT 12'h014
`define FLA_STORE_SEL 3'h2

`define FLA_CTRL_ENABLE 0
`define FLA_CTRL_LOCAL_FINAL 1
`define FLA_STS_LINE_BREAK 0
`define FLA_STS_SEND_ACT 1
`define FLA_STS_RECV_ACT 2
`define FLA_STS_CFG_ERROR 3
`define FLA_STS_RUNNING 4
`define FLA_STS_SEND_ERROR 5
`define FLA_STS_DUP_FINAL 6

`define FLA_CTRL_RESET 2'h0
`define FLA_AREA_RESET 16'h0000
`define FLA_FINAL_RESET 8'h00
`define FLA_RESP_OKAY 2'h0
`define FLA_RESP_SLVERR 2'h2

`endif

// ---- logic/fla_pin_sync.v ----
`timescale 1ns/1ps
module fla_pin_sync #(
  parameter WIDTH = 8
) (
  input wire mclk,
  input wire rst,
  input wire [WIDTH-1:0] pinIn,
  output reg [WIDTH-1:0] pinOut
);
  reg [WIDTH-1:0] stage1Reg;
  reg [WIDTH-1:0] stage2Reg;
  reg [WIDTH-1:0] stage3Reg;

  // Three stages; output follows once stages two and three agree
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      stage1Reg <= {WIDTH{1'b0}};
      stage2Reg <= {WIDTH{1'b0}};
      stage3Reg <= {WIDTH{1'b0}};
      pinOut <= {WIDTH{1'b0}};
    end else begin
      stage1Reg <= pinIn;
      stage2Reg <= stage1Reg;
      stage3Reg <= stage2Reg;
      if (stage2Reg == stage3Reg) begin
        pinOut <= stage3Reg;
      end
    end
  end
endmodule

// ---- logic/fla_cfg_check.v ----
`timescale 1ns/1ps
module fla_cfg_check (
  input wire [7:0] sendStart,
  input wire [7:0] sendCount,
  input wire [7:0] recvStart,
  input wire [7:0] recvCount,
  input wire [7:0] finalAddr,
  input wire localFinal,
  output wire cfgError
);
  wire [8:0] sendEnd;
  wire [8:0] recvEnd;
  wire [8:0] finalEnd;
  wire rangeErr;
  wire overlapErr;
  wire finalErr;
  wire reachErr;

  // Each area is one run from its start, so it stays contiguous
  assign sendEnd = {1'b0, sendStart} + {1'b0, sendCount};
  assign recvEnd = {1'b0, recvStart} + {1'b0, recvCount};
  assign finalEnd = {1'b0, finalAddr} + 9'h001;
  assign rangeErr = (sendEnd > 9'h100) || (recvEnd > 9'h100);

  // Own send and receive areas must not share a number
  assign overlapErr = (sendCount != 8'h00) && (recvCount != 8'h00) &&
                      ({1'b0, sendStart} < recvEnd) && ({1'b0, recvStart} < sendEnd);

  // Local marker only when the master owns the largest send address
  assign finalErr = localFinal ? ((sendCount != 8'h00) && (finalEnd != sendEnd))
                               : ((sendCount != 8'h00) && (finalEnd <= sendEnd));

  // Both areas must lie inside the exchange cycle
  assign reachErr = (sendEnd > finalEnd) || (recvEnd > finalEnd);

  assign cfgError = rangeErr || overlapErr || finalErr || reachErr;
endmodule

// ---- logic/fla_link_master.v ----
`timescale 1ns/1ps
`include "fla_link_regs.vh"
module fla_link_master #(
  parameter ADDR_W = 12,
  parameter ANS_TIMEOUT_CYC = `FLA_ANS_TIMEOUT_CYC
) (
  input wire mclk,
  input wire rst,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg linkTxValid,
  output reg [7:0] linkTxAddr,
  output reg [7:0] linkTxData,
  input wire linkTxReady,
  input wire linkRxValid,
  input wire [7:0] linkRxAddr,
  input wire [7:0] linkRxData,
  input wire linkAnswer,
  input wire linkAnswerCollide,
  input wire linkRemoteFinal,
  output reg lineBreakErrorFlag,
  output reg sendActivityFlag,
  output reg receiveActivityFlag,
  output wire linkActivityIndicator
);
  localparam ST_IDLE = 6'b000001;
  localparam ST_STEP = 6'b000010;
  localparam ST_SEND = 6'b000100;
  localparam ST_ANS = 6'b001000;
  localparam ST_RECV = 6'b010000;
  localparam ST_END = 6'b100000;
  localparam [31:0] TIMEOUT_FULL = ANS_TIMEOUT_CYC - 1;
  localparam [15:0] TIMEOUT_LAST = TIMEOUT_FULL[15:0];

  // Link device storage, one byte per link address
  reg [7:0] linkStore [0:255];

  reg [1:0] ctrlReg;
  reg [15:0] sendAreaReg;
  reg [15:0] recvAreaReg;
  reg [7:0] finalAddrReg;
  reg [31:0] cycleCountReg;
  reg sendErrorReg;
  reg [5:0] stateReg;
  reg [7:0] curAddrReg;
  reg [15:0] timerReg;
  reg rxValidDlyReg;
  reg awHeldReg;
  reg [ADDR_W-1:0] awAddrReg;
  reg wHeldReg;
  reg [31:0] wDataReg;
  reg [3:0] wStrbReg;

  wire [20:0] pinSync;
  wire rxValidS;
  wire [7:0] rxAddrS;
  wire [7:0] rxDataS;
  wire answerS;
  wire collideS;
  wire remoteFinalS;
  wire txReadyS;
  wire cfgError;
  wire localFinal;
  wire enable;
  wire dupFinal;
  wire finalPresent;
  wire rxStrobe;
  wire doWrite;
  wire clrLineBreak;
  wire clrSendError;
  wire [7:0] sendStart;
  wire [7:0] sendCount;
  wire [7:0] recvStart;
  wire [7:0] recvCount;
  wire [6:0] rdWord;
  wire [6:0] wrWord;
  wire running;

  // Membership of an address in one start/count area
  function inArea;
    input [7:0] addr;
    input [7:0] start;
    input [7:0] count;
    reg [8:0] lastPlus;
    begin
      lastPlus = {1'b0, start} + {1'b0, count};
      inArea = ({1'b0, addr} >= {1'b0, start}) && ({1'b0, addr} < lastPlus);
    end
  endfunction

  // Register address decode shared by read and write paths
  function isReg;
    input [ADDR_W-1:0] addr;
    input [11:0] ofs;
    begin
      isReg = (addr[11:0] == ofs);
    end
  endfunction

  function isStore;
    input [ADDR_W-1:0] addr;
    begin
      isStore = (addr[11:9] == `FLA_STORE_SEL);
    end
  endfunction

  // All link-side inputs come from pins
  fla_pin_sync #(
    .WIDTH(21)
  ) u_pin_sync (
    .mclk(mclk),
    .rst(rst),
    .pinIn({linkRxValid, linkRxAddr, linkRxData, linkAnswer, linkAnswerCollide, linkRemoteFinal, linkTxReady}),
    .pinOut(pinSync)
  );

  assign rxValidS = pinSync[20];
  assign rxAddrS = pinSync[19:12];
  assign rxDataS = pinSync[11:4];
  assign answerS = pinSync[3];
  assign collideS = pinSync[2];
  assign remoteFinalS = pinSync[1];
  assign txReadyS = pinSync[0];

  assign sendStart = sendAreaReg[7:0];
  assign sendCount = sendAreaReg[15:8];
  assign recvStart = recvAreaReg[7:0];
  assign recvCount = recvAreaReg[15:8];
  assign enable = ctrlReg[`FLA_CTRL_ENABLE];
  assign localFinal = ctrlReg[`FLA_CTRL_LOCAL_FINAL];

  fla_cfg_check u_cfg_check (
    .sendStart(sendStart),
    .sendCount(sendCount),
    .recvStart(recvStart),
    .recvCount(recvCount),
    .finalAddr(finalAddrReg),
    .localFinal(localFinal),
    .cfgError(cfgError)
  );

  // Marker presence and duplication seen from the master
  assign finalPresent = localFinal || remoteFinalS;
  assign dupFinal = localFinal && remoteFinalS;
  assign rxStrobe = rxValidS && !rxValidDlyReg;
  assign running = (stateReg != ST_IDLE);
  assign linkActivityIndicator = sendActivityFlag || receiveActivityFlag;

  // AXI write channels are accepted independently, then answered
  assign s_axi_awready = !awHeldReg && !s_axi_bvalid;
  assign s_axi_wready = !wHeldReg && !s_axi_bvalid;
  assign doWrite = awHeldReg && wHeldReg && !s_axi_bvalid;
  assign clrLineBreak = doWrite && isReg(awAddrReg, `FLA_OFS_STATUS) && wStrbReg[0] &&
                        wDataReg[`FLA_STS_LINE_BREAK];
  assign clrSendError = doWrite && isReg(awAddrReg, `FLA_OFS_STATUS) && wStrbReg[0] &&
                        wDataReg[`FLA_STS_SEND_ERROR];
  assign wrWord = awAddrReg[8:2];
  assign rdWord = s_axi_araddr[8:2];
  assign s_axi_arready = !s_axi_rvalid;

  // Write path: holding registers, config registers and response
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      awHeldReg <= 1'b0;
      awAddrReg <= {ADDR_W{1'b0}};
      wHeldReg <= 1'b0;
      wDataReg <= 32'h0000_0000;
      wStrbReg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FLA_RESP_OKAY;
      ctrlReg <= `FLA_CTRL_RESET;
      sendAreaReg <= `FLA_AREA_RESET;
      recvAreaReg <= `FLA_AREA_RESET;
      finalAddrReg <= `FLA_FINAL_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeldReg <= 1'b1;
        awAddrReg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeldReg <= 1'b1;
        wDataReg <= s_axi_wdata;
        wStrbReg <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeldReg <= 1'b0;
        wHeldReg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `FLA_RESP_OKAY;
        // No answer-suppress bit exists in the master's control
        if (isReg(awAddrReg, `FLA_OFS_CTRL)) begin
          if (wStrbReg[0]) begin
            ctrlReg <= wDataReg[1:0];
          end
        end else if (isReg(awAddrReg, `FLA_OFS_SEND_AREA)) begin
          if (wStrbReg[0]) begin
            sendAreaReg[7:0] <= wDataReg[7:0];
          end
          if (wStrbReg[1]) begin
            sendAreaReg[15:8] <= wDataReg[15:8];
          end
        end else if (isReg(awAddrReg, `FLA_OFS_RECV_AREA)) begin
          if (wStrbReg[0]) begin
            recvAreaReg[7:0] <= wDataReg[7:0];
          end
          if (wStrbReg[1]) begin
            recvAreaReg[15:8] <= wDataReg[15:8];
          end
        end else if (isReg(awAddrReg, `FLA_OFS_FINAL_ADDR)) begin
          if (wStrbReg[0]) begin
            finalAddrReg <= wDataReg[7:0];
          end
        end else if (!isReg(awAddrReg, `FLA_OFS_STATUS) && !isStore(awAddrReg)) begin
          s_axi_bresp <= `FLA_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Storage writes: software word first, link reception wins a clash
  always @(posedge mclk) begin
    if (doWrite && isStore(awAddrReg)) begin
      if (wStrbReg[0]) begin
        linkStore[{wrWord, 1'b0}] <= wDataReg[7:0];
      end
      if (wStrbReg[1]) begin
        linkStore[{wrWord, 1'b1}] <= wDataReg[15:8];
      end
    end
    if ((stateReg == ST_RECV) && rxStrobe && (rxAddrS == curAddrReg)) begin
      linkStore[curAddrReg] <= rxDataS;
    end
  end

  // Read path: one cycle from address to data
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `FLA_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `FLA_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      if (isStore(s_axi_araddr)) begin
        s_axi_rdata <= {16'h0000, linkStore[{rdWord, 1'b1}], linkStore[{rdWord, 1'b0}]};
      end else if (isReg(s_axi_araddr, `FLA_OFS_CTRL)) begin
        s_axi_rdata <= {30'h0000_0000, ctrlReg};
      end else if (isReg(s_axi_araddr, `FLA_OFS_SEND_AREA)) begin
        s_axi_rdata <= {16'h0000, sendAreaReg};
      end else if (isReg(s_axi_araddr, `FLA_OFS_RECV_AREA)) begin
        s_axi_rdata <= {16'h0000, recvAreaReg};
      end else if (isReg(s_axi_araddr, `FLA_OFS_FINAL_ADDR)) begin
        s_axi_rdata <= {24'h00_0000, finalAddrReg};
      end else if (isReg(s_axi_araddr, `FLA_OFS_STATUS)) begin
        s_axi_rdata <= {25'h000_0000, dupFinal, sendErrorReg, running, cfgError,
                        receiveActivityFlag, sendActivityFlag, lineBreakErrorFlag};
      end else if (isReg(s_axi_araddr, `FLA_OFS_CYCLE_COUNT)) begin
        s_axi_rdata <= cycleCountReg;
      end else begin
        s_axi_rresp <= `FLA_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // While enabled, activity flags stay lit unless exactly one marker is present
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sendActivityFlag <= 1'b0;
      receiveActivityFlag <= 1'b0;
      rxValidDlyReg <= 1'b0;
    end else begin
      sendActivityFlag <= enable && (dupFinal || !finalPresent);
      receiveActivityFlag <= enable && (dupFinal || !finalPresent);
      rxValidDlyReg <= rxValidS;
    end
  end

  // Exchange cycle: walk addresses up to the final one
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      stateReg <= ST_IDLE;
      curAddrReg <= 8'h00;
      timerReg <= 16'h0000;
      linkTxValid <= 1'b0;
      linkTxAddr <= 8'h00;
      linkTxData <= 8'h00;
      lineBreakErrorFlag <= 1'b0;
      sendErrorReg <= 1'b0;
      cycleCountReg <= 32'h0000_0000;
    end else begin
      // Sticky errors: a clear loses against a same-cycle set
      if (clrLineBreak) begin
        lineBreakErrorFlag <= 1'b0;
      end
      if (clrSendError) begin
        sendErrorReg <= 1'b0;
      end
      case (stateReg)
        ST_IDLE: begin
          curAddrReg <= 8'h00;
          // Start only with a valid map and a single marker
          if (enable && !cfgError && finalPresent && !dupFinal) begin
            stateReg <= ST_STEP;
          end
        end
        ST_STEP: begin
          timerReg <= 16'h0000;
          if (inArea(curAddrReg, sendStart, sendCount)) begin
            linkTxValid <= 1'b1;
            linkTxAddr <= curAddrReg;
            linkTxData <= linkStore[curAddrReg];
            stateReg <= ST_SEND;
          end else if (inArea(curAddrReg, recvStart, recvCount)) begin
            stateReg <= ST_RECV;
          end else if (curAddrReg == finalAddrReg) begin
            stateReg <= ST_END;
          end else begin
            curAddrReg <= curAddrReg + 8'h01;
          end
        end
        ST_SEND: begin
          if (txReadyS) begin
            linkTxValid <= 1'b0;
            stateReg <= ST_ANS;
          end
        end
        ST_ANS: begin
          if (collideS) begin
            sendErrorReg <= 1'b1;
            stateReg <= ST_IDLE;
          end else if (answerS) begin
            if (curAddrReg == finalAddrReg) begin
              stateReg <= ST_END;
            end else begin
              curAddrReg <= curAddrReg + 8'h01;
              stateReg <= ST_STEP;
            end
          end else if (timerReg == TIMEOUT_LAST) begin
            lineBreakErrorFlag <= 1'b1;
            stateReg <= ST_IDLE;
          end else begin
            timerReg <= timerReg + 16'h0001;
          end
        end
        ST_RECV: begin
          if (rxStrobe && (rxAddrS == curAddrReg)) begin
            if (curAddrReg == finalAddrReg) begin
              stateReg <= ST_END;
            end else begin
              curAddrReg <= curAddrReg + 8'h01;
              stateReg <= ST_STEP;
            end
          end else if (timerReg == TIMEOUT_LAST) begin
            lineBreakErrorFlag <= 1'b1;
            stateReg <= ST_IDLE;
          end else begin
            timerReg <= timerReg + 16'h0001;
          end
        end
        ST_END: begin
          cycleCountReg <= cycleCountReg + 32'h0000_0001;
          stateReg <= ST_IDLE;
        end
        default: begin
          stateReg <= ST_IDLE;
          linkTxValid <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ---- dv/fla_link_master_chk.sv ----
`timescale 1ns/1ps
module fla_link_master_chk (
  input wire mclk,
  input wire rst,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire linkTxValid,
  input wire [7:0] linkTxAddr,
  input wire [7:0] linkTxData,
  input wire linkTxReady,
  input wire lineBreakErrorFlag,
  input wire sendActivityFlag,
  input wire receiveActivityFlag,
  input wire linkActivityIndicator
);
  // One clock domain, quiet during reset
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Register bus answers and their holding
  chk_b_follows:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_b_holds:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_r_follows:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  chk_r_holds:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  // Link byte offer is held until the far side is ready
  chk_tx_stable:
    assert property (linkTxValid && $past(linkTxValid) |-> $stable(linkTxAddr) && $stable(linkTxData))
    else $error("link byte changed while offered");
  chk_tx_release:
    assert property ($fell(linkTxValid) |-> $past(linkTxReady, 2))
    else $error("link byte withdrawn without ready");
  // Status outputs
  chk_ind_or:
    assert property (linkActivityIndicator == (sendActivityFlag || receiveActivityFlag))
    else $error("activity indicator mismatch");
  chk_break_sticky:
    assert property (lineBreakErrorFlag && !$past(s_axi_awvalid) && !$past(s_axi_wvalid) && !s_axi_bvalid
                     |=> lineBreakErrorFlag)
    else $error("line break flag cleared without write");
endmodule

bind fla_link_master fla_link_master_chk chk (.*);

// ---- dv/fla_slave_model.sv ----
`timescale 1ns/1ps
module fla_slave_model #(
  parameter IN_SPAN = 2
) (
  input wire mclk,
  input wire linkTxValid,
  input wire [7:0] linkTxAddr,
  input wire [7:0] linkTxData,
  input wire ansOn,
  input wire colOn,
  output reg linkTxReady,
  output reg linkAnswer,
  output reg linkAnswerCollide,
  output reg linkRxValid,
  output reg [7:0] linkRxAddr,
  output reg [7:0] linkRxData
);
  reg [7:0] got [0:255];
  integer txCount;
  integer i;
  // Output units: take the byte, let the ready sync drain, then answer
  initial begin
    linkTxReady = 1'b0;
    linkAnswer = 1'b0;
    linkAnswerCollide = 1'b0;
    txCount = 0;
    forever begin
      @(posedge mclk);
      if (linkTxValid) begin
        got[linkTxAddr] = linkTxData;
        repeat (2) @(posedge mclk);
        linkTxReady <= 1'b1;
        while (linkTxValid) @(posedge mclk);
        linkTxReady <= 1'b0;
        repeat (4) @(posedge mclk);
        linkAnswer <= ansOn | colOn;
        linkAnswerCollide <= colOn;
        repeat (5) @(posedge mclk);
        linkAnswer <= 1'b0;
        linkAnswerCollide <= 1'b0;
        txCount = txCount + 1;
      end
    end
  end
  // Input unit spans IN_SPAN addresses from 0; released lines show the inverse
  // A 16-point unit spans two; an analog input unit would span eight, or four
  initial begin
    linkRxValid = 1'b0;
    linkRxAddr = 8'hff;
    linkRxData = 8'hff;
    forever for (i = 0; i < IN_SPAN; i = i + 1) begin
      @(posedge mclk);
      linkRxAddr <= i[7:0];
      linkRxData <= i[7:0] ^ 8'ha5;
      repeat (5) @(posedge mclk);
      linkRxValid <= 1'b1;
      repeat (5) @(posedge mclk);
      linkRxValid <= 1'b0;
      repeat (5) @(posedge mclk);
      linkRxAddr <= ~linkRxAddr;
      linkRxData <= ~linkRxData;
    end
  end
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg [11:0] s_axi_awaddr = 12'h000;
  reg s_axi_awvalid = 1'b0;
  reg [31:0] s_axi_wdata = 32'h0000_0000;
  reg [3:0] s_axi_wstrb = 4'hf;
  reg s_axi_wvalid = 1'b0;
  reg s_axi_bready = 1'b0;
  reg [11:0] s_axi_araddr = 12'h000;
  reg s_axi_arvalid = 1'b0;
  reg s_axi_rready = 1'b0;
  reg linkRemoteFinal = 1'b0;
  reg ansOn = 1'b1;
  reg colOn = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire linkTxValid, linkTxReady, linkRxValid, linkAnswer, linkAnswerCollide;
  wire [7:0] linkTxAddr, linkTxData, linkRxAddr, linkRxData;
  wire lineBreakErrorFlag, sendActivityFlag, receiveActivityFlag, linkActivityIndicator;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [3:0] s;
    logic [1:0] br;
    logic [31:0] q;
    logic [1:0] rr;
  } fla_row_t;
  fla_row_t rows [0:6];
  integer mismatches = 0;
  integer comparisons = 0;
  integer i, k, n;
  reg [31:0] data;
  reg [1:0] resp;

  fla_link_master #(.ANS_TIMEOUT_CYC(60)) DUT (.*);
  fla_slave_model slave (.*);

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  task check(input string nm, input [31:0] exp, input [31:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
    end
  endtask

  // Bus write: address and data offered together, each dropped when taken
  task wr(input [11:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
    begin
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
        @(posedge mclk);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) begin
          r = s_axi_bresp;
          s_axi_bready <= 1'b0;
          break;
        end
      end
    end
  endtask

  // Bus read
  task rd(input [11:0] a, output [31:0] d, output [1:0] r);
    begin
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
        @(posedge mclk);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) begin
          d = s_axi_rdata;
          r = s_axi_rresp;
          s_axi_rready <= 1'b0;
          break;
        end
      end
    end
  endtask

  task final_report;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge mclk);
    mismatches = mismatches + 1;
    final_report;
  end

  initial begin
    rows[0] = '{12'h004, 32'h0000_0204, 4'hf, 2'h0, 32'h0000_0204, 2'h0};
    rows[1] = '{12'h008, 32'h0000_0200, 4'hf, 2'h0, 32'h0000_0200, 2'h0};
    rows[2] = '{12'h00c, 32'h0000_0005, 4'hf, 2'h0, 32'h0000_0005, 2'h0};
    rows[3] = '{12'h404, 32'hffff_beef, 4'hf, 2'h0, 32'h0000_beef, 2'h0};
    rows[4] = '{12'h404, 32'h0000_1234, 4'h1, 2'h0, 32'h0000_be34, 2'h0};
    rows[5] = '{12'h300, 32'h0000_0001, 4'hf, 2'h2, 32'h0000_0000, 2'h2};
    rows[6] = '{12'h000, 32'h0000_0002, 4'hf, 2'h0, 32'h0000_0002, 2'h0};
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    // Register rows: write, read back, compare
    for (i = 0; i < 7; i = i + 1) begin
      wr(rows[i].a, rows[i].d, rows[i].s, resp);
      check("bresp", {30'h0, rows[i].br}, {30'h0, resp});
      rd(rows[i].a, data, resp);
      check("rresp", {30'h0, rows[i].rr}, {30'h0, resp});
      if (rows[i].rr == 2'h0) check("rdata", rows[i].q, data);
    end
    // Exchange with the master holding the only marker
    wr(12'h408, 32'h0000_c35a, 4'hf, resp);
    wr(12'h000, 32'h0000_0003, 4'hf, resp);
    n = slave.txCount + 4;
    for (k = 0; k < 3000 && slave.txCount < n; k = k + 1) @(posedge mclk);
    if (k >= 3000) mismatches = mismatches + 1;
    check("send4", 32'h0000_005a, {24'h0, slave.got[4]});
    check("send5", 32'h0000_00c3, {24'h0, slave.got[5]});
    rd(12'h400, data, resp);
    check("store0", 32'h0000_a4a5, data);
    check("actOff", 32'h0000_0000, {29'h0, sendActivityFlag, receiveActivityFlag, linkActivityIndicator});
    // Silent receivers: link reported broken until cleared
    ansOn <= 1'b0;
    for (k = 0; k < 2000 && lineBreakErrorFlag !== 1'b1; k = k + 1) @(posedge mclk);
    check("break", 32'h0000_0001, {31'h0, lineBreakErrorFlag});
    ansOn <= 1'b1;
    repeat (200) @(posedge mclk);
    wr(12'h010, 32'h0000_0001, 4'hf, resp);
    rd(12'h010, data, resp);
    check("breakClr", 32'h0000_0000, {31'h0, data[0]});
    // Colliding answers abort the exchange
    colOn <= 1'b1;
    // Two answers: the first may already have been under way without collision
    n = slave.txCount + 2;
    for (k = 0; k < 2000 && slave.txCount < n; k = k + 1) @(posedge mclk);
    if (k >= 2000) mismatches = mismatches + 1;
    colOn <= 1'b0;
    repeat (20) @(posedge mclk);
    rd(12'h010, data, resp);
    check("sendErr", 32'h0000_0001, {31'h0, data[5]});
    // A second marker stops the exchange and keeps activity lit
    linkRemoteFinal <= 1'b1;
    repeat (300) @(posedge mclk);
    n = slave.txCount;
    check("actDup", 32'h0000_0007, {29'h0, sendActivityFlag, receiveActivityFlag, linkActivityIndicator});
    rd(12'h010, data, resp);
    check("dupFlag", 32'h0000_0001, {31'h0, data[6]});
    wr(12'h000, 32'h0000_0001, 4'hf, resp);
    linkRemoteFinal <= 1'b0;
    repeat (300) @(posedge mclk);
    check("actNone", 32'h0000_0007, {29'h0, sendActivityFlag, receiveActivityFlag, linkActivityIndicator});
    check("txHeld", n, slave.txCount);
    // Overlapping areas are refused
    wr(12'h000, 32'h0000_0003, 4'hf, resp);
    wr(12'h008, 32'h0000_0204, 4'hf, resp);
    rd(12'h010, data, resp);
    check("cfgErr", 32'h0000_0001, {31'h0, data[3]});
    // Reset in mid-run clears configuration and flags
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      rd(i[11:0] * 12'h004, data, resp);
      check("resetVal", 32'h0000_0000, data);
    end
    check("actRst", 32'h0000_0000, {29'h0, sendActivityFlag, receiveActivityFlag, lineBreakErrorFlag});
    final_report;
  end
endmodule
